//--- core/ulhc_map.vh
// register offsets, field positions and fixed values of the legacy host config header
`ifndef ULHC_MAP_VH
`define ULHC_MAP_VH
`define ULHC_OFF_IO_WINDOW_BASE 8'h20
`define ULHC_OFF_SUBSYS_VENDOR 8'h2c
`define ULHC_OFF_SUBSYS 8'h2e
`define ULHC_OFF_INT_LINE 8'h3c
`define ULHC_OFF_INT_PIN 8'h3d
`define ULHC_OFF_RELEASE 8'h60
`define ULHC_BASE_HI 15
`define ULHC_BASE_LO 5
`define ULHC_BASE_RESET 32'h00000001
`define ULHC_INT_LINE_RESET 8'h00
`define ULHC_RELEASE_VALUE 8'h10
`define ULHC_PIN_FN0 8'h01
`define ULHC_PIN_FN1 8'h02
`define ULHC_PIN_FN2 8'h03
`endif

//--- core/ulhc_config_header.v
// configuration header slice of one legacy usb host function
`include "ulhc_map.vh"

module ulhc_config_header #(
	parameter [1:0] FUNC_NUM = 2'd0
) (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// configuration cycle port, dword addressed, byte enables
	input wire cfg_rd,
	input wire cfg_wr,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	output reg cfg_ack,
	// i/o cycle address for window decode
	input wire [15:0] io_addr,
	output reg io_hit,
	// disk function subsystem identity, same clock
	input wire [15:0] disk_fn_subsystem_vendor,
	input wire [15:0] disk_fn_subsystem,
	// controller interrupt and routing
	input wire ctrl_irq,
	output reg irq_request_input_a,
	output reg irq_request_input_b,
	output reg irq_request_input_c,
	output reg irq_request_input_d
);

	// byte offsets kept at their own width; the dword compare lives in a function
	localparam [7:0] OFF_BASE = `ULHC_OFF_IO_WINDOW_BASE;
	localparam [7:0] OFF_SUB_VENDOR = `ULHC_OFF_SUBSYS_VENDOR;
	localparam [7:0] OFF_INT_LINE = `ULHC_OFF_INT_LINE;
	localparam [7:0] OFF_REL = `ULHC_OFF_RELEASE;

	// reset and fixed values, held as sized constants so slices are explicit
	localparam [31:0] BASE_RESET = `ULHC_BASE_RESET;
	localparam [7:0] INT_LINE_RESET = `ULHC_INT_LINE_RESET;
	localparam [7:0] REL_VALUE = `ULHC_RELEASE_VALUE;
	localparam [7:0] PIN_FN0 = `ULHC_PIN_FN0;
	localparam [7:0] PIN_FN1 = `ULHC_PIN_FN1;
	localparam [7:0] PIN_FN2 = `ULHC_PIN_FN2;

	// bit 0 of the base register marks the window as i/o space
	localparam [0:0] IO_SPACE_INDICATOR = 1'b1;

	// true when a config address falls in the dword holding the given byte offset
	function dword_hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			// bits 1:0 pick a byte inside the dword and play no part in decode
			dword_hit = (addr[7:2] == off[7:2]);
		end
	endfunction

	// merge byte lanes 0 and 1 of a write into the stored base bits 15:5
	function [10:0] base_merge;
		input [10:0] cur;
		input [1:0] be;
		input [15:0] wd;
		begin
			// untouched lanes keep their stored bits
			base_merge = cur;
			// lane 0 carries bits 7:5; bits 4:0 of that lane are fixed or reserved
			if (be[0])
				base_merge[2:0] = wd[7:5];
			// lane 1 carries bits 15:8
			if (be[1])
				base_merge[10:3] = wd[15:8];
		end
	endfunction

	// pin code per function number; unknown numbers fall back to function 0
	function [2:0] pin_of;
		input [1:0] fn;
		begin
			case (fn)
				2'd1: pin_of = PIN_FN1[2:0];
				2'd2: pin_of = PIN_FN2[2:0];
				default: pin_of = PIN_FN0[2:0];
			endcase
		end
	endfunction

	// stored window base bits 15:5 and their next value
	reg [10:0] base_r;
	reg [10:0] base_nxt;
	// interrupt line scratch byte and its next value
	reg [7:0] int_line_r;
	reg [7:0] int_line_nxt;
	// read data chosen for the current request
	reg [31:0] rdata_nxt;
	// acknowledge for the current request
	reg ack_nxt;
	// window compare result for the current i/o address
	reg io_hit_nxt;
	// routed interrupt requests before their output flops
	reg irq_a_nxt;
	reg irq_b_nxt;
	reg irq_c_nxt;
	reg irq_d_nxt;

	// read-only pin field; the strap parameter fixes it for the life of the part
	wire [2:0] interrupt_pin_field = pin_of(FUNC_NUM);
	// scratch byte as software sees it
	wire [7:0] interrupt_line_field = int_line_r;
	// mirrored identity values, passed through live from the disk function
	wire [15:0] subsystem_vendor_value = disk_fn_subsystem_vendor;
	wire [15:0] subsystem_value = disk_fn_subsystem;

	// write strobes per stored register; the pin byte shares the line dword but stores nothing
	wire wr_base = cfg_wr & dword_hit(cfg_addr, OFF_BASE);
	wire wr_int_line = cfg_wr & dword_hit(cfg_addr, OFF_INT_LINE) & cfg_be[0];

	// read selects per mapped dword
	wire rd_base = dword_hit(cfg_addr, OFF_BASE);
	wire rd_sub = dword_hit(cfg_addr, OFF_SUB_VENDOR);
	wire rd_int = dword_hit(cfg_addr, OFF_INT_LINE);
	wire rd_rel = dword_hit(cfg_addr, OFF_REL);

	// next values of the stored registers; all other writes fall away silently
	always @* begin
		base_nxt = base_r;
		int_line_nxt = int_line_r;
		// only bits 15:5 of the base are kept, so bit 0 and reserved bits stay fixed
		if (wr_base) begin
			base_nxt = base_merge(base_r, cfg_be[1:0], cfg_wdata[15:0]);
		end
		// scratch byte is stored and read back, never used by the logic
		if (wr_int_line) begin
			int_line_nxt = cfg_wdata[7:0];
		end
	end

	// stored registers; reset leaves only the i/o space indicator set
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			base_r <= BASE_RESET[15:5];
			int_line_r <= INT_LINE_RESET;
		end else begin
			base_r <= base_nxt;
			int_line_r <= int_line_nxt;
		end
	end

	// read mux; unmapped dwords and reserved bits read zero
	always @* begin
		rdata_nxt = 32'h00000000;
		if (rd_base) begin
			// reserved bits 31:16 and 4:1 are tied low
			rdata_nxt = {16'h0000, base_r, 4'h0, IO_SPACE_INDICATOR};
		end else if (rd_sub) begin
			// both mirrors share one dword: vendor low, subsystem high
			rdata_nxt = {subsystem_value, subsystem_vendor_value};
		end else if (rd_int) begin
			// pin bits 7:3 are reserved and read zero
			rdata_nxt = {16'h0000, 5'h00, interrupt_pin_field, interrupt_line_field};
		end else if (rd_rel) begin
			// release number is a constant; writes to it have no path in
			rdata_nxt = {24'h000000, REL_VALUE};
		end
		// writes answer with zero data so the bus never sees stale values
		if (!cfg_rd) begin
			rdata_nxt = 32'h00000000;
		end
	end

	// every request is answered once, one cycle later
	always @* begin
		ack_nxt = cfg_rd | cfg_wr;
	end

	// registered answer; keeps the answer clean of decode glitches
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_rdata <= 32'h00000000;
			cfg_ack <= 1'b0;
		end else begin
			cfg_rdata <= rdata_nxt;
			cfg_ack <= ack_nxt;
		end
	end

	// i/o window claim: compare address bits 15:5 against the base
	always @* begin
		io_hit_nxt = (io_addr[`ULHC_BASE_HI:`ULHC_BASE_LO] == base_r);
	end

	// registered claim; the decode is a cycle late, which the i/o side must allow for
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			io_hit <= 1'b0;
		end else begin
			io_hit <= io_hit_nxt;
		end
	end

	// routing ignores the reported pin code; function 1 goes to d to spread load
	always @* begin
		irq_a_nxt = ctrl_irq & (FUNC_NUM == 2'd0);
		// input b is never driven by any of these functions
		irq_b_nxt = 1'b0;
		irq_c_nxt = ctrl_irq & (FUNC_NUM == 2'd2);
		irq_d_nxt = ctrl_irq & (FUNC_NUM == 2'd1);
	end

	// routed requests from flops; the scratch byte plays no part here
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_request_input_a <= 1'b0;
			irq_request_input_b <= 1'b0;
			irq_request_input_c <= 1'b0;
			irq_request_input_d <= 1'b0;
		end else begin
			irq_request_input_a <= irq_a_nxt;
			irq_request_input_b <= irq_b_nxt;
			irq_request_input_c <= irq_c_nxt;
			irq_request_input_d <= irq_d_nxt;
		end
	end

	// limitation: the mirrors follow the disk function live; its write-once lock is there
	// limitation: byte lanes 2 and 3 hold only reserved or read-only bits and are ignored

endmodule

//--- verif/ulhc_bridge.sv
// host bridge model issuing one-cycle config requests
module ulhc_bridge(input wire clk,output logic cfg_rd=0,cfg_wr=0,
output logic [7:0] cfg_addr=0,output logic [3:0] cfg_be=0,output logic [31:0] cfg_wdata=0);
timeunit 1ns;timeprecision 1ns;
// raise at a falling edge, taken at the next rising edge, dropped at the falling edge after it
task cyc(input w,input [7:0] ad,input [31:0] dt);
	@(negedge clk) {cfg_rd,cfg_wr,cfg_addr,cfg_be,cfg_wdata}={!w,w,ad,4'hf,dt};
	@(negedge clk) {cfg_rd,cfg_wr,cfg_wdata}={2'b0,~dt};
endtask
endmodule

//--- verif/ulhc_chk.sv
// port checks for the config header slice
module ulhc_chk #(parameter [1:0] FUNC_NUM=0)(input wire clk,arst_n,cfg_rd,cfg_wr,cfg_ack,
input wire ctrl_irq,irq_request_input_a,irq_request_input_b,irq_request_input_c,
input wire irq_request_input_d,input wire [7:0] cfg_addr,input wire [31:0] cfg_rdata);
timeunit 1ns;timeprecision 1ns;
default clocking @(posedge clk);endclocking
default disable iff(!arst_n);
sequence rd_of(x);cfg_rd&&cfg_addr[7:2]==x;endsequence
ack_pulse_a:assert property(cfg_rd|cfg_wr|=>cfg_ack)else $error("ack");
ack_cause_a:assert property(cfg_ack|->$past(cfg_rd|cfg_wr))else $error("ack");
idle_data_a:assert property(!cfg_ack|->!cfg_rdata)else $error("data");
base_bits_a:assert property(rd_of(8)|=>cfg_rdata[31:16]==0&&cfg_rdata[4:0]==1)
else $error("base");
pin_code_a:assert property(rd_of(15)|=>cfg_rdata[31:8]==FUNC_NUM+1)else $error("pin");
release_a:assert property(rd_of(24)|=>cfg_rdata==32'h10)else $error("release");
route_d_a:assert property(1|=>irq_request_input_d==(FUNC_NUM==1&&$past(ctrl_irq)))
else $error("route");
spare_b_a:assert property(!irq_request_input_b)else $error("route");
route_a_a:assert property(1|=>irq_request_input_a==(FUNC_NUM==0&&$past(ctrl_irq)))
else $error("route a");
route_c_a:assert property(1|=>irq_request_input_c==(FUNC_NUM==2&&$past(ctrl_irq)))
else $error("route c");
endmodule
bind ulhc_config_header ulhc_chk #(.FUNC_NUM(FUNC_NUM)) chk_u(.*);

//--- verif/ulhc_tb_top.sv
// self-checking bench for one header function
`define CK(x,y) begin checks++;if((x)!==(y))begin failures++;$display("unexpected %0t value mismatch",$time);end end
module ulhc_tb_top;timeunit 1ns;timeprecision 1ns;
logic clk=0,arst_n=0,ctrl_irq=0;logic [15:0] io_addr=0,disk_fn_subsystem_vendor,disk_fn_subsystem;
int seed=32'h3e67db0e,checks=0,failures=0;logic [31:0] r,q[$];wire [31:0] cfg_wdata,cfg_rdata;
wire cfg_rd,cfg_wr,cfg_ack,io_hit,irq_request_input_d;wire [7:0] cfg_addr;wire [3:0] cfg_be;
wire irq_request_input_a,irq_request_input_c;
always #5 clk=!clk;
ulhc_bridge br(.*);
ulhc_config_header #(.FUNC_NUM(2'd1)) dut_u(.*,.irq_request_input_b());
task rw(input w,input [7:0] ad,input [31:0] dt,ex);q.push_back(ex);br.cyc(w,ad,dt);endtask
// every ack carries a result, checked once settled
always @(negedge clk) if(cfg_ack===1) `CK(cfg_rdata,q.pop_front())
initial begin
	r=$random(seed);
	{disk_fn_subsystem,disk_fn_subsystem_vendor}=r;
	repeat(2) @(negedge clk);
	arst_n=1;
	rw(0,8'h20,0,1);rw(0,8'h3c,0,32'h200);
	rw(1,8'h20,r,0);rw(0,8'h20,0,{r[15:5],5'h1});
	io_addr={r[15:5],5'h1f};@(negedge clk) `CK(io_hit,1)
	io_addr[5]=!io_addr[5];@(negedge clk) `CK(io_hit,1'b0)
	rw(1,8'h3c,r,0);rw(0,8'h3c,0,{8'h2,r[7:0]});
	rw(1,8'h60,r,0);rw(0,8'h60,0,32'h10);ctrl_irq=1;
	rw(0,8'h2c,0,r);
	`CK(irq_request_input_d,1'b1)
	`CK({irq_request_input_a,irq_request_input_c},2'b00)
	@(negedge clk) `CK(q.size(),0)
	report_and_stop;
end
initial begin #2000;failures++;report_and_stop;end
task report_and_stop;$display("checks %0d failures %0d",checks,failures);
if(failures==0&&checks>0) $display("SIMULATION PASSED");
else $display("SIMULATION FAILED");
$finish;endtask
endmodule
